// >>> rtl/vis_buf.sv
`timescale 1ns/1ps

module vis_buf
  import vis_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input vis_pix_s in_data,
  output logic out_valid,
  input wire logic out_ready,
  output vis_pix_s out_data
);

  // ----------------------------------------
  // Two-entry skid: head drives the output
  // ----------------------------------------
  vis_pix_s tail_r;
  logic tail_v_r;
  logic pop;
  logic push;

  assign in_ready = ~tail_v_r;
  assign pop = out_valid & out_ready;
  assign push = in_valid & in_ready;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
      tail_r <= '0;
      tail_v_r <= 1'b0;
    end
    else if (pop)
    begin
      if (tail_v_r)
      begin
        out_data <= tail_r;
        tail_v_r <= 1'b0;
      end
      else
      begin
        out_valid <= push;
        if (push)
          out_data <= in_data;
      end
    end
    else if (push)
    begin
      if (!out_valid)
      begin
        out_data <= in_data;
        out_valid <= 1'b1;
      end
      else
      begin
        tail_r <= in_data;
        tail_v_r <= 1'b1;
      end
    end
  end

  a_buf_no_loss: assert property (@(posedge clk) disable iff (!nrst)
    (out_valid && !out_ready) |=> out_valid && $stable(out_data))
    else $error("buffer head changed while stalled");

endmodule : vis_buf

// >>> rtl/vis_params.svh
`ifndef VIS_PARAMS_SVH
`define VIS_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define VIS_OFS_INPUT_PORT_CONTROL 8'h00
`define VIS_OFS_SYNC_ROUTING_SELECT 8'h18

// ----------------------------------------
// input_port_control fields
// ----------------------------------------
`define VIS_IPC_EXT_SELECT 0
`define VIS_IPC_DATA_EDGE 1
`define VIS_IPC_SIGNED_INPUT_EN 2
`define VIS_IPC_FORM_ON 3
`define VIS_IPC_TEST_PIC_ON 4
`define VIS_IPC_SYNC_EDGE 5
`define VIS_IPC_LINE_SYNC_POLARITY 6
`define VIS_IPC_FRAME_SYNC_POLARITY 7

// ----------------------------------------
// sync_routing_select fields
// ----------------------------------------
`define VIS_SRS_CS_SEL 0
`define VIS_SRS_INPUT_REGEN_LINE_SEL 1
`define VIS_SRS_VS_OUT_EN 2
`define VIS_SRS_SOG_OUT_EN 3
`define VIS_SRS_FRAME_SYNC_DELAY_EN 4
`define VIS_SRS_HSYNC_EDGE 5

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define VIS_POS_W 12
`define VIS_DLY_W 8
`define VIS_JIT_W 8
`define VIS_REG_RESET 8'h00
`define VIS_ASYNC_W 55

`endif

// >>> rtl/vis_pkg.sv
package vis_pkg;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } vis_pix_s;

  typedef struct packed {
    logic [11:0] v_offset;
    logic [11:0] v_length;
    logic [11:0] h_offset;
    logic [11:0] h_length;
    logic clamp_en;
    logic clamp_pol;
    logic [7:0] clamp_on_delay;
    logic [7:0] clamp_off_delay;
    logic gainc_en;
    logic gainc_pol;
    logic [7:0] gainc_on_delay;
    logic [7:0] gainc_off_delay;
    logic [7:0] jitter_count_threshold;
  } vis_cfg_s;

  typedef enum logic [0:0] {
    VIS_NO_FRAME,
    VIS_IN_FRAME
  } vis_frame_e;

endpackage : vis_pkg

// >>> rtl/vis_top.sv
// Contract
// - Composite select routes decoded or regenerated syncs
// - Frame pin direction and output source select
// - Source select picks parallel port or converters
// - Data edge bit picks rising or falling
// - Signed bit treats external data as two's complement
// - Converter data always two's complement
// - No pixels pass unless formatter enabled
// - Test generator pixels replace sampled data
// - Polarity bits set sync active level
// - Sync edge bit picks rising or falling
// - Frame sync delay avoids coincident edge jitter
// - Vertical offset counted from frame sync trailing
// - Horizontal offset from leading or second edge
// - Zero offsets capture first pixel, first line
// - Window captures exact programmed width and height
// - Clamp pulse between delays after second edge
// - Gain pulse is delayed line sync
// - Jitter flag above programmed count threshold
// - Converters enabled when analog source selected
`timescale 1ns/1ps
`include "vis_params.svh"

module vis_top
  import vis_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] input_port_control,
  input wire logic [7:0] sync_routing_select,
  input vis_cfg_s cfg,
  input wire logic fe_clk,
  input wire logic line_sync_pin,
  input wire logic frame_sync_pin_i,
  output logic frame_sync_pin_o,
  output logic frame_sync_pin_oe,
  input wire logic decoded_line_sync,
  input wire logic decoded_frame_sync,
  input wire logic regenerated_line_sync,
  input wire logic green_sync,
  input vis_pix_s ext_pix,
  input vis_pix_s adc_pix,
  input wire logic gen_valid,
  input vis_pix_s gen_pix,
  output logic pix_valid,
  input wire logic pix_ready,
  output vis_pix_s pix_data,
  output logic clamp_out,
  output logic gainc_out,
  output logic adc_enable,
  output logic line_jitter_flag,
  output logic pix_overrun
);

  // ----------------------------------------
  // Control bits
  // ----------------------------------------
  logic ext_select, data_edge, signed_input_en, form_on, test_pic_on, sync_edge;
  logic line_sync_polarity, frame_sync_polarity;
  logic cs_sel, input_regen_line_sel, vs_out_en, sog_out_en, frame_sync_delay_en, hsync_edge;

  assign ext_select = input_port_control[`VIS_IPC_EXT_SELECT];
  assign data_edge = input_port_control[`VIS_IPC_DATA_EDGE];
  assign signed_input_en = input_port_control[`VIS_IPC_SIGNED_INPUT_EN];
  assign form_on = input_port_control[`VIS_IPC_FORM_ON];
  assign test_pic_on = input_port_control[`VIS_IPC_TEST_PIC_ON];
  assign sync_edge = input_port_control[`VIS_IPC_SYNC_EDGE];
  assign line_sync_polarity = input_port_control[`VIS_IPC_LINE_SYNC_POLARITY];
  assign frame_sync_polarity = input_port_control[`VIS_IPC_FRAME_SYNC_POLARITY];
  assign cs_sel = sync_routing_select[`VIS_SRS_CS_SEL];
  assign input_regen_line_sel = sync_routing_select[`VIS_SRS_INPUT_REGEN_LINE_SEL];
  assign vs_out_en = sync_routing_select[`VIS_SRS_VS_OUT_EN];
  assign sog_out_en = sync_routing_select[`VIS_SRS_SOG_OUT_EN];
  assign frame_sync_delay_en = sync_routing_select[`VIS_SRS_FRAME_SYNC_DELAY_EN];
  assign hsync_edge = sync_routing_select[`VIS_SRS_HSYNC_EDGE];

  // ----------------------------------------
  // Synchronisers for pins and front-end clock
  // ----------------------------------------
  logic [`VIS_ASYNC_W-1:0] meta_r, sy_r;
  logic fe_prev_r;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r <= '0;
      sy_r <= '0;
      fe_prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= {fe_clk, line_sync_pin, frame_sync_pin_i, decoded_line_sync, decoded_frame_sync,
                 regenerated_line_sync, green_sync, ext_pix, adc_pix};
      sy_r <= meta_r;
      fe_prev_r <= sy_r[54];
    end
  end

  logic fe_s, hs_pin_s, vs_pin_s, dec_hs_s, dec_vs_s, regen_s, sog_s;
  vis_pix_s ext_s, adc_s;
  assign {fe_s, hs_pin_s, vs_pin_s, dec_hs_s, dec_vs_s, regen_s, sog_s, ext_s, adc_s} = sy_r;

  // Front-end edges found in the system clock; the link clock is far slower
  logic fe_rise, fe_fall, data_tick, sync_tick;
  assign fe_rise = fe_s & ~fe_prev_r;
  assign fe_fall = ~fe_s & fe_prev_r;
  assign data_tick = data_edge ? fe_rise : fe_fall;
  assign sync_tick = sync_edge ? fe_rise : fe_fall;

  // ----------------------------------------
  // Sync routing and polarity
  // ----------------------------------------
  logic ls_raw, fs_raw, ls_act, fs_act;
  assign ls_raw = cs_sel ? (input_regen_line_sel ? regen_s : dec_hs_s) : hs_pin_s;
  assign fs_raw = cs_sel ? dec_vs_s : vs_pin_s;
  assign ls_act = line_sync_polarity ? ls_raw : ~ls_raw;
  assign fs_act = frame_sync_polarity ? fs_raw : ~fs_raw;

  logic ls_q_r, ls_q2_r, fs_q_r, fs_d_r, fs_use_q_r, tick_d_r;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ls_q_r <= 1'b0;
      ls_q2_r <= 1'b0;
      fs_q_r <= 1'b0;
      fs_d_r <= 1'b0;
      fs_use_q_r <= 1'b0;
      tick_d_r <= 1'b0;
    end
    else
    begin
      tick_d_r <= sync_tick;
      if (sync_tick)
      begin
        ls_q_r <= ls_act;
        ls_q2_r <= ls_q_r;
        fs_q_r <= fs_act;
        // One sample of lag keeps frame edges off line edges
        fs_d_r <= frame_sync_delay_en ? fs_q_r : fs_act;
        fs_use_q_r <= fs_d_r;
      end
    end
  end

  logic ls_lead, ls_trail, fs_trail, line_ref;
  assign ls_lead = tick_d_r & ls_q_r & ~ls_q2_r;
  assign ls_trail = tick_d_r & ~ls_q_r & ls_q2_r;
  assign fs_trail = tick_d_r & ~fs_d_r & fs_use_q_r;
  assign line_ref = hsync_edge ? ls_lead : ls_trail;

  // ----------------------------------------
  // Sample window
  // ----------------------------------------
  vis_frame_e frame_r;
  logic [`VIS_POS_W-1:0] vline_r, hpos_r;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      frame_r <= VIS_NO_FRAME;
      vline_r <= '1;
      hpos_r <= '1;
    end
    else
    begin
      if (fs_trail)
      begin
        frame_r <= VIS_IN_FRAME;
        vline_r <= '1;
      end
      else if (line_ref)
        vline_r <= vline_r + 1'b1;
      if (line_ref)
        hpos_r <= '0;
      else if (data_tick && hpos_r != '1)
        hpos_r <= hpos_r + 1'b1;
    end
  end

  function automatic logic in_span(input logic [11:0] pos, input logic [11:0] ofs, input logic [11:0] len);
    logic [12:0] end_pos;
    end_pos = {1'b0, ofs} + {1'b0, len};
    in_span = ({1'b0, pos} >= {1'b0, ofs}) && ({1'b0, pos} < end_pos);
  endfunction : in_span

  logic v_in, h_in, in_win;
  assign v_in = (frame_r == VIS_IN_FRAME) && in_span(vline_r, cfg.v_offset, cfg.v_length);
  assign h_in = in_span(hpos_r, cfg.h_offset, cfg.h_length);
  assign in_win = v_in && h_in;

  // ----------------------------------------
  // Pixel path
  // ----------------------------------------
  vis_pix_s src_pix, fmt_pix, push_pix;
  logic push_valid, push_ready;
  always_comb
  begin
    src_pix = ext_select ? ext_s : adc_s;
    fmt_pix = src_pix;
    if (ext_select && !signed_input_en)
    begin
      // Unsigned input moved into two's complement by flipping the sign bit
      fmt_pix.red[7] = ~src_pix.red[7];
      fmt_pix.green[7] = ~src_pix.green[7];
      fmt_pix.blue[7] = ~src_pix.blue[7];
    end
    push_pix = test_pic_on ? gen_pix : fmt_pix;
    push_valid = form_on && (test_pic_on ? gen_valid : (data_tick && in_win));
  end

  vis_buf u_buf (
    .clk(clk),
    .nrst(nrst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_pix),
    .out_valid(pix_valid),
    .out_ready(pix_ready),
    .out_data(pix_data)
  );

  // The sampled source cannot be stalled, so a full buffer is only reported
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pix_overrun <= 1'b0;
    else if (push_valid && !push_ready)
      pix_overrun <= 1'b1;
  end

  // ----------------------------------------
  // Clamp and gain correction pulses
  // ----------------------------------------
  logic [`VIS_DLY_W-1:0] ccnt_r, gon_cnt_r, goff_cnt_r;
  logic crun_r, gon_run_r, goff_run_r, gact_r;
  logic clamp_act;
  assign clamp_act = crun_r && ccnt_r >= cfg.clamp_on_delay && ccnt_r < cfg.clamp_off_delay;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ccnt_r <= '0;
      crun_r <= 1'b0;
    end
    else if (ls_trail)
    begin
      ccnt_r <= '0;
      crun_r <= 1'b1;
    end
    else if (data_tick && crun_r)
    begin
      ccnt_r <= ccnt_r + 1'b1;
      crun_r <= ccnt_r != '1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      gon_cnt_r <= '0;
      goff_cnt_r <= '0;
      gon_run_r <= 1'b0;
      goff_run_r <= 1'b0;
      gact_r <= 1'b0;
    end
    else
    begin
      if (ls_lead)
      begin
        gon_cnt_r <= '0;
        gon_run_r <= 1'b1;
      end
      else if (gon_run_r && gon_cnt_r == cfg.gainc_on_delay)
      begin
        gact_r <= 1'b1;
        gon_run_r <= 1'b0;
      end
      else if (data_tick && gon_run_r)
        gon_cnt_r <= gon_cnt_r + 1'b1;
      if (ls_trail)
      begin
        goff_cnt_r <= '0;
        goff_run_r <= 1'b1;
      end
      else if (goff_run_r && goff_cnt_r == cfg.gainc_off_delay)
      begin
        gact_r <= 1'b0;
        goff_run_r <= 1'b0;
      end
      else if (data_tick && goff_run_r)
        goff_cnt_r <= goff_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      clamp_out <= 1'b0;
      gainc_out <= 1'b0;
      adc_enable <= 1'b0;
      frame_sync_pin_o <= 1'b0;
      frame_sync_pin_oe <= 1'b0;
    end
    else
    begin
      clamp_out <= (cfg.clamp_en && clamp_act) ? cfg.clamp_pol : ~cfg.clamp_pol;
      gainc_out <= (cfg.gainc_en && gact_r) ? cfg.gainc_pol : ~cfg.gainc_pol;
      adc_enable <= ~ext_select;
      frame_sync_pin_oe <= vs_out_en;
      frame_sync_pin_o <= vs_out_en && (sog_out_en ? sog_s : dec_vs_s);
    end
  end

  // ----------------------------------------
  // Line jitter detection
  // ----------------------------------------
  logic [1:0] len_r, prev_len_r;
  logic [`VIS_JIT_W-1:0] jcnt_r;
  logic jit_active;
  // Only the low bits matter: sampling jitter moves a line by two cycles at most
  assign jit_active = !ext_select && (!form_on || v_in);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      len_r <= '0;
      prev_len_r <= '0;
      jcnt_r <= '0;
      line_jitter_flag <= 1'b0;
    end
    else
    begin
      if (ls_lead)
      begin
        len_r <= '0;
        prev_len_r <= len_r;
      end
      else if (data_tick)
        len_r <= len_r + 1'b1;
      if (fs_trail)
        jcnt_r <= '0;
      else if (ls_lead && jit_active && len_r != prev_len_r && jcnt_r != '1)
        jcnt_r <= jcnt_r + 1'b1;
      // Set wins over the clear at the frame edge
      if (jcnt_r > cfg.jitter_count_threshold)
        line_jitter_flag <= 1'b1;
      else if (fs_trail)
        line_jitter_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_adc_follows_src: assert property (##1 $stable(ext_select) |=> adc_enable == !$past(ext_select))
    else $error("converter enable wrong");
  a_push_in_window: assert property (push_valid && !test_pic_on |-> in_win && data_tick)
    else $error("pixel pushed outside window");
  a_form_off_quiet: assert property (!form_on |-> !push_valid)
    else $error("pixel pushed while formatter off");
  a_vs_pin_dir: assert property (frame_sync_pin_oe |-> $past(vs_out_en))
    else $error("frame pin driven while input");
  a_vs_pin_idle: assert property (!frame_sync_pin_oe |-> !frame_sync_pin_o)
    else $error("frame pin value while not driving");
  a_line_restart: assert property (line_ref |=> hpos_r == 0)
    else $error("pixel count not restarted");
  a_frame_restart: assert property (fs_trail && !line_ref |=> vline_r == 12'hfff)
    else $error("line count not restarted");
  a_clamp_level: assert property (!cfg.clamp_en ##1 !cfg.clamp_en |-> clamp_out == !$past(cfg.clamp_pol))
    else $error("clamp active while disabled");
  a_jit_flag_set: assert property (jcnt_r > cfg.jitter_count_threshold |=> line_jitter_flag)
    else $error("jitter flag missed");
  a_unsigned_conv: assert property (ext_select && !signed_input_en && !test_pic_on
    |-> push_pix.red == (ext_s.red ^ 8'h80))
    else $error("unsigned input not converted");

  c_pixel_out: cover property (pix_valid && pix_ready);
  c_jitter: cover property ($rose(line_jitter_flag));
  c_overrun: cover property ($rose(pix_overrun));
  c_clamp: cover property (cfg.clamp_en && clamp_out == cfg.clamp_pol);

endmodule : vis_top

// >>> tb/test_video_input_window_sampler.sv
`timescale 1ns/1ps

module test_video_input_window_sampler
  import vis_pkg::*;
  ;
  // {jit, form, regen, cs, hsedge, rise, signed, ext}
  localparam logic [7:0] RUNS [6] = '{8'h4d, 8'h45, 8'h5b, 8'h7c, 8'h8c, 8'h4d};
  logic clk;
  logic nrst;
  logic [7:0] ipc;
  logic [7:0] srs;
  vis_cfg_s cfg;
  logic go, lpol, fpol, jit, done, ls, fs, fe_clk, gs_r, dfs_r, gen_valid, pix_ready, stall;
  logic fpin_o, fpin_oe, pix_valid, clamp_out, gainc_out, adc_en, jit_flag, overrun;
  vis_pix_s src, gen_pix, pix_data;
  int mismatches, samples_checked, cycles, cl_len, cl_n, gc_len, gc_n;
  int seed = 32'hee99;
  int gs [2];
  vis_pix_s got [$];
  vis_pix_s gexp [$];
  wire cs = srs[0];
  wire regen = srs[1];
  wire ext = ipc[0];

  vis_src_model src_m (.go(go), .edge_rise(ipc[1]), .lpol(lpol), .fpol(fpol), .jit(jit), .fe_clk(fe_clk),
    .ls(ls), .fs(fs), .pix(src), .done(done));

  vis_top uut (.clk(clk), .nrst(nrst), .input_port_control(ipc), .sync_routing_select(srs), .cfg(cfg),
    .fe_clk(fe_clk), .line_sync_pin(cs ? !lpol : ls), .frame_sync_pin_i(fpin_oe ? fpin_o : (cs ? !fpol : fs)),
    .frame_sync_pin_o(fpin_o), .frame_sync_pin_oe(fpin_oe), .decoded_line_sync(cs && !regen ? ls : !lpol),
    .decoded_frame_sync(cs ? fs : dfs_r), .regenerated_line_sync(cs && regen ? ls : !lpol), .green_sync(gs_r),
    .ext_pix(ext ? src : ~src), .adc_pix(ext ? ~src : src), .gen_valid(gen_valid), .gen_pix(gen_pix),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data), .clamp_out(clamp_out),
    .gainc_out(gainc_out), .adc_enable(adc_en), .line_jitter_flag(jit_flag), .pix_overrun(overrun));

  // ------------------------------
  // Clock, checks and monitors
  // ------------------------------
  initial
  begin
    clk = 1'b0;
    forever
      #50 clk = !clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // First pulse after reset may be partial, so it is skipped
  task automatic pulse(input logic act, inout int len, inout int n, input int want, input string what);
    if (act)
      len++;
    else if (len > 0)
    begin
      if (n > 0)
        chk(what, len, want);
      n++;
      len = 0;
    end
  endtask : pulse

  always @(posedge clk)
  begin
    cycles++;
    if (cycles >= 60000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  always @(posedge clk)
  begin
    if (nrst !== 1'b1)
    begin
      cl_len = 0;
      cl_n = 0;
      gc_len = 0;
      gc_n = 0;
    end
    else
    begin
      pulse(clamp_out === cfg.clamp_pol, cl_len, cl_n, 16, "clamp width");
      pulse(gainc_out === cfg.gainc_pol, gc_len, gc_n, 24, "gain width");
    end
    if (pix_valid === 1'b1 && pix_ready === 1'b1)
      got.push_back(pix_data);
    #1 pix_ready = !stall && ($random(seed) % 2 != 0);
  end

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic do_run(input int r, input logic [7:0] m);
    int g0;
    int row;
    logic [7:0] mk;
    nrst = 1'b0;
    stall = (r == 5);
    lpol = 1'($random(seed));
    fpol = 1'($random(seed));
    jit = m[7];
    cfg.clamp_pol = 1'($random(seed));
    cfg.gainc_pol = 1'($random(seed));
    // One run with the clamp off so its idle level is exercised while lines run
    cfg.clamp_en = (r != 3);
    // Source and routing change only while held in reset
    ipc = {fpol, lpol, m[2], 1'b0, m[6], m[1], m[2], m[0]};
    srs = {2'b00, m[3], 1'($random(seed)), 2'b00, m[5], m[4]};
    tick(8);
    nrst = 1'b1;
    tick(4);
    chk("adc_enable", adc_en, !m[0]);
    got.delete();
    go = 1'b1;
    for (int k = 0; k < 5000 && done !== 1'b1; k++)
      tick(1);
    chk("source done", done, 1'b1);
    go = 1'b0;
    chk("overrun", overrun, stall);
    stall = 1'b0;
    tick(30);
    mk = (m[0] && !m[1]) ? 8'h80 : 8'h00;
    chk("count", got.size(), m[6] ? (r == 5 ? 2 : 30) : 0);
    g0 = (got.size() > 0) ? int'(got[0].green ^ mk) : 0;
    if (r < 2)
      gs[r] = g0;
    foreach (got[k])
    begin
      row = (k % 15) / 5;
      chk("pixel", got[k], {8'(4 + row), 8'(g0 + k % 5), 8'((4 + row) * 16 + g0 + k % 5)} ^ {3{mk}});
    end
    chk("jitter flag", jit_flag, m[7]);
    chk("clamp pulses", cl_n > 2, cfg.clamp_en);
    chk("gain pulses", gc_n > 2, 1'b1);
    $display("run %0d done", r);
  endtask : do_run

  task automatic gen_run();
    nrst = 1'b0;
    ipc = 8'h18;
    srs = 8'h00;
    tick(8);
    nrst = 1'b1;
    tick(4);
    got.delete();
    repeat (10)
    begin
      gen_pix = 24'($random(seed));
      gexp.push_back(gen_pix);
      gen_valid = 1'b1;
      tick(1);
      gen_valid = 1'b0;
      // Wide spacing so random ready gaps cannot fill both buffer slots
      tick(15);
    end
    tick(20);
    chk("gen count", got.size(), 10);
    foreach (gexp[k])
      chk("gen pixel", got[k], gexp[k]);
    for (int k = 0; k < 4; k++)
    begin
      gs_r = 1'($random(seed));
      dfs_r = 1'($random(seed));
      srs = {4'h0, k[1], k[0], 2'b00};
      tick(5);
      chk("pin oe", fpin_oe, k[0]);
      if (k[0])
        chk("pin out", fpin_o, k[1] ? gs_r : dfs_r);
    end
    $display("generator run done");
  endtask : gen_run

  initial
  begin
    nrst = 1'b0;
    ipc = 8'h00;
    srs = 8'h00;
    cfg = '0;
    cfg.v_offset = 12'h002;
    cfg.v_length = 12'h003;
    cfg.h_offset = 12'h003;
    cfg.h_length = 12'h005;
    cfg.clamp_en = 1'b1;
    cfg.clamp_on_delay = 8'h01;
    cfg.clamp_off_delay = 8'h03;
    cfg.gainc_en = 1'b1;
    cfg.gainc_on_delay = 8'h01;
    cfg.gainc_off_delay = 8'h02;
    cfg.jitter_count_threshold = 8'h02;
    go = 1'b0;
    lpol = 1'b0;
    fpol = 1'b0;
    jit = 1'b0;
    gs_r = 1'b0;
    dfs_r = 1'b0;
    gen_valid = 1'b0;
    gen_pix = '0;
    pix_ready = 1'b0;
    stall = 1'b0;
    for (int r = 0; r < 6; r++)
    begin
      do_run(r, RUNS[r]);
      if (r == 1)
        chk("line edge shift", gs[1] - gs[0], 2);
    end
    gen_run();
    give_verdict();
  end
endmodule : test_video_input_window_sampler

// >>> tb/vis_src_model.sv
`timescale 1ns/1ps

// ------------------------------
// Parallel video source model
// ------------------------------
module vis_src_model
  import vis_pkg::*;
(
  input wire logic go,
  input wire logic edge_rise,
  input wire logic lpol,
  input wire logic fpol,
  input wire logic jit,
  output logic fe_clk,
  output logic ls,
  output logic fs,
  output vis_pix_s pix,
  output logic done
);
  int ln;
  int px;

  // Launch on the unsampled edge so data is settled for half a period
  task automatic put();
    pix = {ln[7:0], px[7:0], 8'(ln * 16 + px)};
    ls = (px < 2) ? lpol : !lpol;
    fs = ((ln == 0 && px >= 8) || (ln == 1 && px < 8)) ? fpol : !fpol;
  endtask : put

  // Clock stands still between bursts of two frames
  initial
  begin
    fe_clk = 1'b0;
    ls = 1'b0;
    fs = 1'b0;
    pix = '0;
    done = 1'b0;
    forever
    begin
      wait (go === 1'b1);
      ln = 11;
      px = 15;
      put();
      repeat (2)
      begin
        for (ln = 0; ln < 12; ln++)
        begin
          // Odd lines one pixel longer when jitter wanted
          for (px = 0; px < 16 + (jit ? ln % 2 : 0); px++)
          begin
            #400 fe_clk = 1'b1;
            if (!edge_rise)
              put();
            #400 fe_clk = 1'b0;
            if (edge_rise)
              put();
          end
        end
      end
      done = 1'b1;
      wait (go === 1'b0);
      done = 1'b0;
    end
  end
endmodule : vis_src_model
